// *** rtl/act_pkg.sv ***
// register map, field layout and carrier types of the advanced control timer
package act_pkg;
  localparam int          ACT_ADDR_W    = 8;
  localparam int          ACT_CNT_W     = 16;
  localparam int          ACT_NCH       = 4;
  localparam int          ACT_NCOMP     = 3;
  localparam int          ACT_DT_W      = 8;
  localparam int          ACT_EVT_W     = 5;
  localparam logic [7:0]  ACT_OFS_CTRL  = 8'h00;
  localparam logic [7:0]  ACT_OFS_PRESC = 8'h04;
  localparam logic [7:0]  ACT_OFS_RELD  = 8'h08;
  localparam logic [7:0]  ACT_OFS_COUNT = 8'h0C;
  localparam logic [7:0]  ACT_OFS_CHCFG = 8'h10;
  localparam logic [7:0]  ACT_OFS_DEAD  = 8'h14;
  localparam logic [7:0]  ACT_OFS_CMP0  = 8'h20;
  localparam logic [7:0]  ACT_OFS_CMP1  = 8'h24;
  localparam logic [7:0]  ACT_OFS_CMP2  = 8'h28;
  localparam logic [7:0]  ACT_OFS_CMP3  = 8'h2C;
  localparam logic [7:0]  ACT_OFS_STAT  = 8'h30;
  localparam logic [7:0]  ACT_OFS_MASK  = 8'h34;
  localparam logic [7:0]  ACT_OFS_DMAEN = 8'h38;
  localparam logic [15:0] ACT_RST_PRESC = 16'h0000;
  localparam logic [15:0] ACT_RST_RELD  = 16'hFFFF;
  localparam logic [7:0]  ACT_RST_DEAD  = 8'h00;
  // event bit positions: update at 0, channel n at n+1
  localparam int          ACT_EVT_UPD   = 0;
  localparam int          ACT_EVT_CH0   = 1;

  typedef enum logic [1:0] {
    ACT_CNT_UP     = 2'h0,
    ACT_CNT_DOWN   = 2'h1,
    ACT_CNT_CENTER = 2'h2
  } act_cmode_t;

  typedef enum logic [1:0] {
    ACT_CH_CAPTURE = 2'h0,
    ACT_CH_TOGGLE  = 2'h1,
    ACT_CH_PWM     = 2'h2,
    ACT_CH_FORCED  = 2'h3
  } act_chmode_t;

  typedef enum logic [1:0] {
    ACT_DIR_UP   = 2'b01,
    ACT_DIR_DOWN = 2'b10
  } act_dir_t;

  typedef struct packed {
    logic       freeze;
    logic       onePulse;
    act_cmode_t cmode;
    logic       enable;
  } act_ctrl_t;

  typedef struct packed {
    logic        outEn;
    logic        fallEdge;
    act_chmode_t mode;
  } act_chcfg_t;

  typedef struct packed {
    logic [ACT_ADDR_W-1:0] addr;
    logic [31:0]           wdata;
    logic                  wr;
    logic                  rd;
  } act_busreq_t;

  localparam act_ctrl_t ACT_RST_CTRL = '{freeze: 1'b0, onePulse: 1'b0,
                                        cmode: ACT_CNT_UP, enable: 1'b0};
endpackage

// *** rtl/act_dead_time.sv ***
// complementary output pair with programmable dead time
`timescale 1ns/1ps
module act_dead_time
  import act_pkg::*;
#(
  parameter int DT_W = ACT_DT_W
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic            en,
  input  wire logic            refIn,
  input  wire logic [DT_W-1:0] deadTime,
  output logic                 outPos,
  output logic                 outNeg
);
  logic            refSeen;
  logic [DT_W-1:0] gapCnt;

  initial begin
    if (DT_W < 1 || DT_W > 16) $error("act_dead_time: DT_W out of range");
  end

  // both legs low for deadTime+1 cycles after every edge of the reference
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      refSeen <= 1'b0;
      gapCnt  <= '0;
      outPos  <= 1'b0;
      outNeg  <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        refSeen <= refIn;
        gapCnt  <= '0;
        outPos  <= 1'b0;
        outNeg  <= 1'b0;
      end else if (refIn != refSeen) begin
        refSeen <= refIn;
        gapCnt  <= deadTime;
        outPos  <= 1'b0;
        outNeg  <= 1'b0;
      end else if (gapCnt != '0) begin
        gapCnt <= gapCnt - 1'b1;
      end else begin
        outPos <= refSeen;
        outNeg <= ~refSeen;
      end
    end
  end
endmodule

// *** rtl/act_timer.sv ***
// advanced control timer: prescaler, 16-bit counter, four channels, register port
`timescale 1ns/1ps
module act_timer
  import act_pkg::*;
#(
  parameter int CNT_W = ACT_CNT_W,
  parameter int NCH   = ACT_NCH,
  parameter int DT_W  = ACT_DT_W
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic [ACT_ADDR_W-1:0] busAddr,
  input  wire logic [31:0]           busWdata,
  input  wire logic                  busWr,
  input  wire logic                  busRd,
  output logic [31:0]                busRdata,
  input  wire logic                  dbgHalt,
  input  wire logic [NCH-1:0]        chIn,
  output logic [NCH-1:0]             chOut,
  output logic [NCH-1:0]             chOe,
  output logic [ACT_NCOMP-1:0]       chOutN,
  output logic [ACT_NCOMP-1:0]       chOeN,
  output logic                       irq,
  output logic [ACT_EVT_W-1:0]       dmaReq
);
  localparam int EVW = NCH + 1;

  act_busreq_t          bus;
  act_ctrl_t            ctrl;
  act_chcfg_t [NCH-1:0] chCfg;
  logic [CNT_W-1:0]     presc;
  logic [CNT_W-1:0]     prescCnt;
  logic [CNT_W-1:0]     reload;
  logic [CNT_W-1:0]     count;
  logic [CNT_W-1:0]     cmp [NCH];
  logic [DT_W-1:0]      deadTime;
  logic [EVW-1:0]       status;
  logic [EVW-1:0]       mask;
  logic [EVW-1:0]       dmaEn;
  logic [EVW-1:0]       evt;
  logic [NCH-1:0]       syncA;
  logic [NCH-1:0]       syncB;
  logic [NCH-1:0]       syncC;
  logic [NCH-1:0]       capEdge;
  logic [NCH-1:0]       refOut;
  logic [NCH-1:0]       cmpHit;
  act_dir_t             dir;
  act_dir_t             next_dir;
  logic [CNT_W-1:0]     next_count;
  logic                 running;
  logic                 tick;
  logic                 updEvt;
  logic                 lastOut;
  wire logic [ACT_NCOMP-1:0] legPos;
  wire logic [ACT_NCOMP-1:0] legNeg;

  initial begin
    if (CNT_W != ACT_CNT_W) $error("act_timer: CNT_W must be 16");
    if (NCH != ACT_NCH) $error("act_timer: NCH must be 4");
    if (DT_W < 1 || DT_W > 16) $error("act_timer: DT_W out of range");
  end

  // write-one-to-clear with the hardware set winning
  function automatic logic [EVW-1:0] flagNext(input logic [EVW-1:0] cur,
                                              input logic [EVW-1:0] set,
                                              input logic [EVW-1:0] clr);
    flagNext = (cur & ~clr) | set;
  endfunction

  function automatic logic isWrite(input act_busreq_t b, input logic [7:0] ofs);
    isWrite = b.wr && (b.addr == ofs);
  endfunction

  assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};

  assign running = ctrl.enable && !(ctrl.freeze && dbgHalt);
  // a lowered divider must not leave the count stranded above it
  assign tick    = running && (prescCnt >= presc);

  // configuration registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      presc    <= ACT_RST_PRESC;
      reload   <= ACT_RST_RELD;
      deadTime <= ACT_RST_DEAD;
      chCfg    <= '0;
      mask     <= '0;
      dmaEn    <= '0;
    end else if (ce) begin
      if (isWrite(bus, ACT_OFS_PRESC)) presc <= bus.wdata[CNT_W-1:0];
      if (isWrite(bus, ACT_OFS_RELD)) reload <= bus.wdata[CNT_W-1:0];
      if (isWrite(bus, ACT_OFS_DEAD)) deadTime <= bus.wdata[DT_W-1:0];
      if (isWrite(bus, ACT_OFS_CHCFG)) chCfg <= bus.wdata[4*NCH-1:0];
      if (isWrite(bus, ACT_OFS_MASK)) mask <= bus.wdata[EVW-1:0];
      if (isWrite(bus, ACT_OFS_DMAEN)) dmaEn <= bus.wdata[EVW-1:0];
    end
  end

  // control; one-pulse mode drops the enable at the update event
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl <= ACT_RST_CTRL;
    end else if (ce) begin
      if (isWrite(bus, ACT_OFS_CTRL)) begin
        ctrl <= act_ctrl_t'(bus.wdata[4:0]);
      end else if (updEvt && ctrl.onePulse) begin
        ctrl.enable <= 1'b0;
      end
    end
  end

  // prescaler
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prescCnt <= '0;
    end else if (ce) begin
      if (!running) prescCnt <= prescCnt;
      else if (tick) prescCnt <= '0;
      else prescCnt <= prescCnt + 1'b1;
    end
  end

  // next counter value per counting mode
  always_comb begin
    next_count = count;
    next_dir   = dir;
    updEvt     = 1'b0;
    if (tick) begin
      case (ctrl.cmode)
        ACT_CNT_DOWN: begin
          updEvt     = (count == '0);
          next_count = updEvt ? reload : count - 1'b1;
        end
        ACT_CNT_CENTER: begin
          case (dir)
            ACT_DIR_UP: begin
              if (count >= reload) begin
                updEvt     = 1'b1;
                next_dir   = ACT_DIR_DOWN;
                next_count = count - 1'b1;
              end else begin
                next_count = count + 1'b1;
              end
            end
            ACT_DIR_DOWN: begin
              if (count == '0) begin
                updEvt     = 1'b1;
                next_dir   = ACT_DIR_UP;
                next_count = count + 1'b1;
              end else begin
                next_count = count - 1'b1;
              end
            end
            default: next_dir = ACT_DIR_UP;
          endcase
        end
        default: begin
          updEvt     = (count >= reload);
          next_count = updEvt ? '0 : count + 1'b1;
        end
      endcase
    end
  end

  // counter; software write wins over counting
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      dir   <= ACT_DIR_UP;
    end else if (ce) begin
      if (isWrite(bus, ACT_OFS_COUNT)) begin
        count <= bus.wdata[CNT_W-1:0];
        dir   <= ACT_DIR_UP;
      end else begin
        count <= next_count;
        dir   <= next_dir;
      end
    end
  end

  // capture pins: two-stage synchroniser, then an edge stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end else if (ce) begin
      syncA <= chIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      capEdge[i] = chCfg[i].fallEdge ? (syncC[i] && !syncB[i]) : (!syncC[i] && syncB[i]);
      cmpHit[i]  = tick && (count == cmp[i]);
    end
  end

  // compare registers, loaded by software or by a capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) cmp[i] <= '0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        if (bus.wr && bus.addr == ACT_OFS_CMP0 + 8'(4 * i)) begin
          cmp[i] <= bus.wdata[CNT_W-1:0];
        end else if (chCfg[i].mode == ACT_CH_CAPTURE && capEdge[i]) begin
          cmp[i] <= count;
        end
      end
    end
  end

  // channel reference waveforms
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      refOut <= '0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        case (chCfg[i].mode)
          ACT_CH_TOGGLE: if (cmpHit[i]) refOut[i] <= ~refOut[i];
          ACT_CH_PWM:    refOut[i] <= ctrl.enable && (count < cmp[i]);
          ACT_CH_FORCED: refOut[i] <= 1'b1;
          default:       refOut[i] <= 1'b0;
        endcase
      end
    end
  end

  // events, sticky status, interrupt and DMA requests
  always_comb begin
    evt              = '0;
    evt[ACT_EVT_UPD] = updEvt;
    for (int i = 0; i < NCH; i++) begin
      evt[ACT_EVT_CH0+i] = (chCfg[i].mode == ACT_CH_CAPTURE) ? capEdge[i] : cmpHit[i];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      dmaReq <= '0;
    end else if (ce) begin
      status <= flagNext(status, evt,
                         isWrite(bus, ACT_OFS_STAT) ? bus.wdata[EVW-1:0] : '0);
      dmaReq <= evt & dmaEn;
    end
  end

  assign irq = |(status & mask);

  // register read port, data one cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busRdata <= '0;
    end else if (ce) begin
      busRdata <= '0;
      if (bus.rd) begin
        case (bus.addr)
          ACT_OFS_CTRL:  busRdata <= 32'(ctrl);
          ACT_OFS_PRESC: busRdata <= 32'(presc);
          ACT_OFS_RELD:  busRdata <= 32'(reload);
          ACT_OFS_COUNT: busRdata <= 32'(count);
          ACT_OFS_CHCFG: busRdata <= 32'(chCfg);
          ACT_OFS_DEAD:  busRdata <= 32'(deadTime);
          ACT_OFS_CMP0:  busRdata <= 32'(cmp[0]);
          ACT_OFS_CMP1:  busRdata <= 32'(cmp[1]);
          ACT_OFS_CMP2:  busRdata <= 32'(cmp[2]);
          ACT_OFS_CMP3:  busRdata <= 32'(cmp[3]);
          ACT_OFS_STAT:  busRdata <= 32'(status);
          ACT_OFS_MASK:  busRdata <= 32'(mask);
          ACT_OFS_DMAEN: busRdata <= 32'(dmaEn);
          default:       busRdata <= '0;
        endcase
      end
    end
  end

  // complementary pairs on the three phase channels
  for (genvar g = 0; g < ACT_NCOMP; g++) begin : gPhase
    act_dead_time #(
      .DT_W(DT_W)
    ) uDead (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .en      (chCfg[g].outEn && chCfg[g].mode != ACT_CH_CAPTURE),
      .refIn   (refOut[g]),
      .deadTime(deadTime),
      .outPos  (legPos[g]),
      .outNeg  (legNeg[g])
    );
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lastOut <= 1'b0;
    end else if (ce) begin
      lastOut <= refOut[NCH-1] && chCfg[NCH-1].outEn;
    end
  end

  assign chOut  = {lastOut, legPos};
  assign chOutN = legNeg;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chOe[i] = chCfg[i].outEn && (chCfg[i].mode != ACT_CH_CAPTURE);
    end
    chOeN = chOe[ACT_NCOMP-1:0];
  end
endmodule

// *** test/act_timer_properties.sv ***
// port-level checks of the advanced control timer
`timescale 1ns/1ps
module act_timer_properties
  import act_pkg::*;
#(
  parameter int NCH = ACT_NCH
) (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire logic [ACT_ADDR_W-1:0] busAddr,
  input wire logic [31:0]           busWdata,
  input wire logic                  busWr,
  input wire logic                  busRd,
  input wire logic [31:0]           busRdata,
  input wire logic                  dbgHalt,
  input wire logic [NCH-1:0]        chIn,
  input wire logic [NCH-1:0]        chOut,
  input wire logic [NCH-1:0]        chOe,
  input wire logic [ACT_NCOMP-1:0]  chOutN,
  input wire logic [ACT_NCOMP-1:0]  chOeN,
  input wire logic                  irq,
  input wire logic [ACT_EVT_W-1:0]  dmaReq
);
  logic freezeOn;

  // shadow of the freeze bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      freezeOn <= 1'b0;
    end else if (ce && busWr && busAddr == ACT_OFS_CTRL) begin
      freezeOn <= busWdata[4];
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_legs_apart: assert property (!(chOut[0] && chOutN[0]))
    else $error("both legs of pair 0 high");
  chk_pos_dead: assert property ($rose(chOut[0]) |-> !$past(chOutN[0]))
    else $error("pos leg rose without gap");
  chk_neg_dead: assert property ($rose(chOutN[0]) |-> !$past(chOut[0]))
    else $error("neg leg rose without gap");
  chk_oen_pair: assert property (chOeN == chOe[2:0])
    else $error("complement enables differ");
  chk_oe_cfg: assert property (ce && busWr && busAddr == ACT_OFS_CHCFG |=>
    chOe == $past({busWdata[15] && busWdata[13:12] != 2'h0,
                   busWdata[11] && busWdata[9:8] != 2'h0,
                   busWdata[7] && busWdata[5:4] != 2'h0,
                   busWdata[3] && busWdata[1:0] != 2'h0}))
    else $error("enables do not follow config");
  chk_rd_quiet: assert property ($past(ce) && !$past(busRd) |-> busRdata == 32'h0)
    else $error("read data outside read slot");
  chk_mask_off: assert property (ce && busWr && busAddr == ACT_OFS_MASK &&
    busWdata[ACT_EVT_W-1:0] == '0 |=> !irq)
    else $error("irq with empty mask");
  chk_halt_hold: assert property ((freezeOn && dbgHalt) [*3] |-> !dmaReq[0])
    else $error("update while frozen");

  cover property ($rose(irq));
  cover property ($rose(chOut[0]));
  cover property (dmaReq[0]);
endmodule

// *** test/act_pin_src.sv ***
// capture signal sources on the channel pins
`timescale 1ns/1ps
module act_pin_src
  import act_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               load,
  input  wire logic [ACT_NCH-1:0] lvl,
  output logic      [ACT_NCH-1:0] chIn
);
  // levels change only on command
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chIn <= '0;
    end else if (load) begin
      chIn <= lvl;
    end
  end
endmodule

// *** test/tb_top.sv ***
// self-checking bench of the advanced control timer
`timescale 1ns/1ps
module tb_top
  import act_pkg::*;
;
  logic        ref_clk  = 1'b0;
  logic        rst      = 1'b1;
  logic        ce       = 1'b1;
  logic        dbgHalt  = 1'b0;
  logic        busWr    = 1'b0;
  logic        busRd    = 1'b0;
  logic        pinLoad  = 1'b0;
  logic [3:0]  pinLvl   = 4'h0;
  logic [7:0]  busAddr  = 8'h00;
  logic [31:0] busWdata = 32'h0;
  logic [31:0] busRdata;
  logic [3:0]  chIn, chOut, chOe;
  logic [2:0]  chOutN, chOeN;
  logic [4:0]  dmaReq;
  logic        irq;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          p, r, d, n, m;

  act_timer act_timer_inst (.ref_clk, .rst, .ce, .busAddr, .busWdata, .busWr, .busRd,
    .busRdata, .dbgHalt, .chIn, .chOut, .chOe, .chOutN, .chOeN, .irq, .dmaReq);
  act_pin_src act_pin_src_inst (.ref_clk, .rst, .load(pinLoad), .lvl(pinLvl), .chIn);

  always #25 ref_clk = ~ref_clk;

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    busAddr <= a;
    busWdata <= v;
    busWr <= 1'b1;
    @(posedge ref_clk);
    busWr <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge ref_clk);
    busRd <= 1'b0;
    #1 chk(busRdata, exp);
  endtask

  // one less than the cycles from one update pulse to the next
  task automatic upd(output int k);
    k = 0;
    tick();
    while (dmaReq[0] !== 1'b1 && k < 3000) begin
      tick();
      k++;
    end
  endtask

  function automatic logic legv(input int leg);
    return leg ? chOutN[0] : chOut[0];
  endfunction

  // length of a full high run, second one seen
  task automatic hiRun(input int leg, output int k);
    repeat (2) begin
      k = 0;
      while (legv(leg) === 1'b1) tick();
      while (legv(leg) === 1'b0) tick();
      while (legv(leg) === 1'b1) begin
        tick();
        k++;
      end
    end
  endtask

  function automatic int expGap(int md, int ps, int rl);
    return (ps + 1) * (md == 2 ? rl : rl + 1);
  endfunction

  initial begin
    void'($urandom(11011));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rc(ACT_OFS_CTRL, 32'h0);
    rc(ACT_OFS_PRESC, 32'(ACT_RST_PRESC));
    rc(ACT_OFS_RELD, 32'(ACT_RST_RELD));
    rc(ACT_OFS_DEAD, 32'(ACT_RST_DEAD));
    rc(8'hFC, 32'h0);
    wr(ACT_OFS_DMAEN, 32'h1F);
    for (int k = 0; k < 6; k++) begin
      m = k % 3;
      p = k < 3 ? 0 : $urandom_range(3);
      r = k < 3 ? 1 : $urandom_range(9, 2);
      wr(ACT_OFS_PRESC, 32'(p));
      wr(ACT_OFS_RELD, 32'(r));
      wr(ACT_OFS_CTRL, 32'(m * 2 + 1));
      upd(n);
      upd(n);
      chk(32'(n + 1), 32'(expGap(m, p, r)));
      wr(ACT_OFS_CTRL, 32'h0);
    end
    wr(ACT_OFS_PRESC, 32'h0);
    wr(ACT_OFS_RELD, 32'h5);
    wr(ACT_OFS_COUNT, 32'h0);
    wr(ACT_OFS_CTRL, 32'h9);
    repeat (12) tick();
    rc(ACT_OFS_CTRL, 32'h8);
    wr(ACT_OFS_MASK, 32'h1);
    #1 chk(32'(irq), 32'h1);
    wr(ACT_OFS_STAT, 32'h1F);
    #1 chk(32'(irq), 32'h0);
    rc(ACT_OFS_STAT, 32'h0);
    wr(ACT_OFS_MASK, 32'h0);
    d = $urandom_range(2);
    wr(ACT_OFS_DEAD, 32'(d));
    wr(ACT_OFS_RELD, 32'd11);
    wr(ACT_OFS_CMP0, 32'h5);
    wr(ACT_OFS_CHCFG, 32'hA);
    #1 chk({chOeN, chOe}, 32'h11);
    for (m = 0; m < 3; m += 2) begin
      wr(ACT_OFS_CTRL, 32'(m * 2 + 1));
      hiRun(0, n);
      chk(32'(n), 32'(m ? 8 - d : 4 - d));
      hiRun(1, n);
      chk(32'(n), 32'(m ? 12 - d : 6 - d));
    end
    wr(ACT_OFS_RELD, 32'hFFFF);
    wr(ACT_OFS_CTRL, 32'h11);
    dbgHalt <= 1'b1;
    wr(ACT_OFS_COUNT, 32'd100);
    repeat (20) tick();
    rc(ACT_OFS_COUNT, 32'd100);
    dbgHalt <= 1'b0;
    repeat (5) tick();
    wr(ACT_OFS_CHCFG, 32'h0);
    for (int e = 0; e < 2; e++) begin
      wr(ACT_OFS_CHCFG, e ? 32'h40 : 32'h0);
      wr(ACT_OFS_STAT, 32'h1F);
      pinLvl <= e ? 4'h0 : 4'h2;
      pinLoad <= 1'b1;
      tick();
      pinLoad <= 1'b0;
      repeat (6) tick();
      rc(ACT_OFS_STAT, 32'h4);
    end
    wrap_up();
  end
endmodule

bind act_timer act_timer_properties #(.NCH(NCH)) act_timer_properties_inst (.ref_clk, .rst,
  .ce, .busAddr, .busWdata, .busWr, .busRd, .busRdata, .dbgHalt, .chIn, .chOut, .chOe,
  .chOutN, .chOeN, .irq, .dmaReq);
